// >>> pbt_pkg.sv
// pbt_pkg: constants and types of the parallel bcd time output unit.
// assumes a 50 MHz system clock and a 32-bit avalon-mm register bus.
package pbt_pkg;

    localparam int CLK_PERIOD_NS  = 20;
    localparam int MS_NS          = 1000000;
    localparam int CYC_PER_MS     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PPS_HIGH_MS    = 10;
    localparam int MS_PER_SEC     = 1000;

    localparam int PAR_W          = 48;
    localparam int TIME_W         = 42;
    localparam int MAIN_W         = 44;
    localparam int AUX_N          = 4;
    localparam int ANA_N          = 2;
    localparam int DIG_SRC_N      = 18;
    localparam int DSEL_W         = 5;

    // register byte offsets
    localparam logic [4:0] REG_CTRL    = 5'h00;
    localparam logic [4:0] REG_DSEL    = 5'h04;
    localparam logic [4:0] REG_ASEL    = 5'h08;
    localparam logic [4:0] REG_STATUS  = 5'h0c;
    localparam logic [4:0] REG_TIME_LO = 5'h10;
    localparam logic [4:0] REG_TIME_HI = 5'h14;
    localparam logic [4:0] REG_DATA_LO = 5'h18;
    localparam logic [4:0] REG_DATA_HI = 5'h1c;

    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] DSEL_RST   = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

    // serial wiring modes
    localparam logic [1:0] SER_NONE = 2'h0;
    localparam logic [1:0] SER_TWO  = 2'h1;
    localparam logic [1:0] SER_FOUR = 2'h2;

    // shared pin indices
    localparam int PIN_RTS = 0;
    localparam int PIN_CTS = 1;
    localparam int PIN_TXD = 2;
    localparam int PIN_RXD = 3;

    typedef struct packed {
        logic [1:0] day_h;
        logic [3:0] day_t;
        logic [3:0] day_u;
        logic [1:0] hr_t;
        logic [3:0] hr_u;
        logic [2:0] min_t;
        logic [3:0] min_u;
        logic [2:0] sec_t;
        logic [3:0] sec_u;
    } pbt_sec_t;

    typedef struct packed {
        pbt_sec_t   sec;
        logic [11:0] ms;
    } pbt_time_t;

    typedef struct packed {
        logic [ANA_N-1:0] ana_en;
        logic [AUX_N-1:0] dig_en;
        logic [1:0]       ser_mode;
        logic             tz_local;
        logic             data_mode;
    } pbt_ctrl_t;

endpackage : pbt_pkg

// >>> pbt_par_time.sv
// pbt_par_time: parallel bcd time bus, 1 pps and 1 kpps outputs and the
// four shared auxiliary pins, with an avalon-mm register slave.
// assumes the clock core hands over the bcd time of the coming second in
// both zones, on this clock, and that sat_pps_i is an asynchronous pin.
//
// Function
// - time mode shows bcd time of year down to single milliseconds.
// - data mode drives a factory fixed word of up to 48 bits.
// - one pulse per second, 10 ms high, rising on reference edge.
// - 1 kHz square wave, rising edges aligned to the reference edge.
// - four digital aux outputs, each selecting one of eighteen sources.
// - two analog aux outputs, each selecting one of two sources.
// - four shared pins never driven by two functions at once.
// - any digital aux enabled on a pin not taken by serial or analog withdraws four bits from the parallel bus.
// - each analog output replaces one digital output and one data bit.
// - two or four wire serial takes that many shared lines.
// - time bus is 42 bits with fixed decimal digit weights.
// - time shown is universal or local per the zone selection.
// - millisecond bit rises within 100 ns of the pps output edge.
module pbt_par_time
    import pbt_pkg::*;
#(
    parameter int            MS_CYCLES = CYC_PER_MS,
    parameter logic [47:0]   DATA_WORD = 48'h0000_0000_0000
)(
    input  wire logic                 sys_clk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic                 clk_en_i,
    input  wire logic                 sat_pps_i,
    input  wire pbt_sec_t             utc_sec_i,
    input  wire pbt_sec_t             local_sec_i,
    input  wire logic [DIG_SRC_N-1:0] dig_src_i,
    input  wire logic                 ser_txd_i,
    input  wire logic                 ser_rts_i,
    output logic                      ser_rxd_o,
    output logic                      ser_cts_o,
    input  wire logic [4:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    input  wire logic [3:0]           avs_byteenable_i,
    output logic [31:0]               avs_readdata_o,
    output logic                      avs_waitrequest_o,
    output logic [MAIN_W-1:0]         par_o,
    input  wire logic [AUX_N-1:0]     aux_pin_i,
    output logic [AUX_N-1:0]          aux_pin_o,
    output logic [AUX_N-1:0]          aux_pin_oe_o,
    output logic [ANA_N-1:0]          ana_en_o,
    output logic [ANA_N-1:0]          ana_sel_o,
    output logic                      pps_o,
    output logic                      kpps_o
);

    localparam int SUB_W = $clog2(MS_CYCLES + 1);
    localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(MS_CYCLES - 1);
    localparam logic [SUB_W-1:0] SUB_HALF = SUB_W'(MS_CYCLES / 2);
    localparam logic [11:0] MS_LAST  = 12'h999;
    localparam logic [11:0] MS_PPS   = 12'h010;

    // bcd increment of a three digit millisecond field
    function automatic logic [11:0] bcd3_inc(input logic [11:0] v);
        logic [11:0] r;
        r = v;
        if (v[3:0] != 4'h9) begin
            r[3:0] = v[3:0] + 4'h1;
        end else begin
            r[3:0] = 4'h0;
            if (v[7:4] != 4'h9) begin
                r[7:4] = v[7:4] + 4'h1;
            end else begin
                r[7:4] = 4'h0;
                r[11:8] = (v[11:8] == 4'h9) ? 4'h0 : v[11:8] + 4'h1;
            end
        end
        return r;
    endfunction : bcd3_inc

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [2:0]       pps_sync;
    logic [AUX_N-1:0] pin_meta;
    logic [AUX_N-1:0] pin_sync;
    logic             pps_rise;

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pps_sync <= 3'h0;
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end else if (clk_en_i) begin
            pps_sync <= {pps_sync[1:0], sat_pps_i};
            pin_meta <= aux_pin_i;
            pin_sync <= pin_meta;
        end
    end

    assign pps_rise = pps_sync[1] & ~pps_sync[2];

    ////////////////////////////////////////////////////////////////////////
    // registers and avalon slave

    pbt_ctrl_t             ctrl;
    logic [AUX_N*DSEL_W-1:0] dsel;
    logic [ANA_N-1:0]      asel;
    logic                  ref_seen;
    logic                  ack;
    logic [31:0]           next_rdata;
    pbt_time_t             cur_time;
    logic [AUX_N-1:0]      pin_taken;

    // single wait cycle, then one acknowledged cycle
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~(ack & clk_en_i);

    always_comb begin
        next_rdata = UNMAPPED_RD;
        unique case (avs_address_i)
            REG_CTRL:    next_rdata = {22'h0, ctrl};
            REG_DSEL:    next_rdata = {12'h0, dsel};
            REG_ASEL:    next_rdata = {30'h0, asel};
            REG_STATUS:  next_rdata = {27'h0, pin_taken, ref_seen};
            REG_TIME_LO: next_rdata = cur_time[31:0];
            REG_TIME_HI: next_rdata = {22'h0, cur_time[41:32]};
            REG_DATA_LO: next_rdata = DATA_WORD[31:0];
            REG_DATA_HI: next_rdata = {16'h0, DATA_WORD[47:32]};
            default:     next_rdata = UNMAPPED_RD;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ack            <= 1'b0;
            avs_readdata_o <= 32'h0000_0000;
        end else if (clk_en_i) begin
            ack <= (avs_read_i | avs_write_i) & ~ack;
            if (avs_read_i & ~ack) begin
                avs_readdata_o <= next_rdata;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl <= CTRL_RST[9:0];
            dsel <= DSEL_RST[19:0];
            asel <= 2'h0;
        end else if (clk_en_i && avs_write_i && ack) begin
            unique case (avs_address_i)
                REG_CTRL: begin
                    if (avs_byteenable_i[0]) ctrl[7:0] <= avs_writedata_i[7:0];
                    if (avs_byteenable_i[1]) ctrl[9:8] <= avs_writedata_i[9:8];
                end
                REG_DSEL: begin
                    if (avs_byteenable_i[0]) dsel[7:0] <= avs_writedata_i[7:0];
                    if (avs_byteenable_i[1]) dsel[15:8] <= avs_writedata_i[15:8];
                    if (avs_byteenable_i[2]) dsel[19:16] <= avs_writedata_i[19:16];
                end
                REG_ASEL: begin
                    if (avs_byteenable_i[0]) asel <= avs_writedata_i[1:0];
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // millisecond timebase locked to the reference

    logic [SUB_W-1:0] sub_cnt;
    logic             ms_tick;

    assign ms_tick = (sub_cnt == SUB_LAST);

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sub_cnt  <= '0;
            ref_seen <= 1'b0;
        end else if (clk_en_i) begin
            if (pps_rise) begin
                sub_cnt  <= '0;
                ref_seen <= 1'b1;
            end else if (ms_tick) begin
                sub_cnt <= '0;
            end else begin
                sub_cnt <= sub_cnt + SUB_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            kpps_o <= 1'b0;
        end else if (clk_en_i) begin
            kpps_o <= pps_rise | ms_tick | (sub_cnt < SUB_HALF - SUB_W'(1));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // time of year register

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cur_time <= '0;
        end else if (clk_en_i) begin
            if (pps_rise) begin
                cur_time.sec <= ctrl.tz_local ? local_sec_i : utc_sec_i;
                cur_time.ms  <= 12'h000;
            end else if (ms_tick) begin
                cur_time.ms <= (cur_time.ms == MS_LAST) ? 12'h000
                                                        : bcd3_inc(cur_time.ms);
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pps_o <= 1'b0;
        end else if (clk_en_i) begin
            if (pps_rise) begin
                pps_o <= 1'b1;
            end else if (ms_tick && bcd3_inc(cur_time.ms) == MS_PPS) begin
                pps_o <= 1'b0;
            end else if (ms_tick && cur_time.ms == MS_LAST) begin
                pps_o <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // parallel bus and shared pin allocation

    logic [PAR_W-1:0] word;
    logic [AUX_N-1:0] ser_take;
    logic [AUX_N-1:0] ana_take;
    logic [AUX_N-1:0] dig_take;
    logic [AUX_N-1:0] next_pin;
    logic [AUX_N-1:0] next_oe;
    logic             any_dig;

    function automatic logic dig_pick(input logic [DSEL_W-1:0] sel,
                                      input logic [DIG_SRC_N-1:0] src);
        return (sel < DSEL_W'(DIG_SRC_N)) ? src[sel] : 1'b0;
    endfunction : dig_pick

    assign word = ctrl.data_mode ? DATA_WORD
                                 : {{(PAR_W-TIME_W){1'b0}}, cur_time};

    always_comb begin
        ser_take = 4'h0;
        if (ctrl.ser_mode == SER_TWO) begin
            ser_take = 4'hc;
        end else if (ctrl.ser_mode == SER_FOUR) begin
            ser_take = 4'hf;
        end
        ana_take = {2'h0, ctrl.ana_en} & ~ser_take;
        dig_take = ctrl.dig_en & ~ser_take & ~ana_take;
        any_dig  = |dig_take;
    end

    assign pin_taken = ser_take | ana_take | dig_take;

    always_comb begin
        for (int i = 0; i < AUX_N; i++) begin
            next_pin[i] = 1'b0;
            next_oe[i]  = 1'b0;
            if (ser_take[i]) begin
                next_oe[i]  = (i == PIN_TXD) || (i == PIN_RTS);
                next_pin[i] = (i == PIN_TXD) ? ser_txd_i : ser_rts_i;
            end else if (ana_take[i]) begin
                next_pin[i] = 1'b0;
            end else if (dig_take[i]) begin
                next_oe[i]  = 1'b1;
                next_pin[i] = dig_pick(dsel[i*DSEL_W +: DSEL_W], dig_src_i);
            end else if (!any_dig) begin
                next_oe[i]  = 1'b1;
                next_pin[i] = word[MAIN_W+i];
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            par_o        <= '0;
            aux_pin_o    <= 4'h0;
            aux_pin_oe_o <= 4'h0;
        end else if (clk_en_i) begin
            par_o        <= word[MAIN_W-1:0];
            aux_pin_o    <= next_pin;
            aux_pin_oe_o <= next_oe;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ana_en_o  <= 2'h0;
            ana_sel_o <= 2'h0;
            ser_rxd_o <= 1'b1;
            ser_cts_o <= 1'b0;
        end else if (clk_en_i) begin
            ana_en_o  <= ana_take[ANA_N-1:0];
            ana_sel_o <= asel;
            ser_rxd_o <= ser_take[PIN_RXD] ? pin_sync[PIN_RXD] : 1'b1;
            ser_cts_o <= ser_take[PIN_CTS] & pin_sync[PIN_CTS];
        end
    end

endmodule : pbt_par_time

// >>> pbt_par_time_monitor.sv
// pbt_par_time_monitor: port-level checks of the parallel time unit.
// assumes an even MS_CYCLES small enough for plain delays.
module pbt_par_time_monitor
    import pbt_pkg::*;
#(
    parameter int MS_CYCLES = 20
)(
    input wire logic              sys_clk_i,
    input wire logic              sys_rst_i,
    input wire logic              sat_pps_i,
    input wire pbt_sec_t          utc_sec_i,
    input wire pbt_sec_t          local_sec_i,
    input wire logic [MAIN_W-1:0] par_o,
    input wire logic [AUX_N-1:0]  aux_pin_oe_o,
    input wire logic [ANA_N-1:0]  ana_en_o,
    input wire logic              pps_o,
    input wire logic              kpps_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int KHALF = MS_CYCLES / 2;
    logic [15:0] hi_cnt;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    // length of the current second pulse
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hi_cnt <= 16'h0000;
        end else begin
            hi_cnt <= pps_o ? hi_cnt + 16'h0001 : 16'h0000;
        end
    end

    sequence s_ref_up;
        $rose(sat_pps_i);
    endsequence
    sequence s_out_up;
        $rose(pps_o) && kpps_o;
    endsequence
    sequence s_kpps_cycle;
        kpps_o ##KHALF $fell(kpps_o) ##KHALF $rose(kpps_o);
    endsequence

    AST_REF_LAT: assert property (s_ref_up |-> ##[2:5] s_out_up)
        else $error("second pulse late after reference edge");
    AST_PPS_WIDTH: assert property ($fell(pps_o) |->
        hi_cnt == 16'(PPS_HIGH_MS * MS_CYCLES))
        else $error("second pulse width wrong");
    AST_KPPS_CYCLE: assert property ($rose(pps_o) |-> s_kpps_cycle)
        else $error("square wave not aligned to second");
    AST_MS_ZERO: assert property ($rose(pps_o) |=>
        par_o[11:0] == 12'h000)
        else $error("millisecond field not zero at second");
    AST_SEC_ZONE: assert property ($rose(pps_o) |=>
        par_o[41:12] == utc_sec_i || par_o[41:12] == local_sec_i)
        else $error("seconds field not from a zone input");
    AST_HOLD_MS: assert property ($rose(pps_o) |=> ##1 $stable(par_o) [*8])
        else $error("time bus moved inside a millisecond");
    AST_ANA_PIN0: assert property (ana_en_o[0] |-> !aux_pin_oe_o[0])
        else $error("pin 0 driven while analog");
    AST_ANA_PIN1: assert property (ana_en_o[1] |-> !aux_pin_oe_o[1])
        else $error("pin 1 driven while analog");
endmodule : pbt_par_time_monitor

bind pbt_par_time pbt_par_time_monitor #(.MS_CYCLES(MS_CYCLES)) mon_u (
    .sys_clk_i    (sys_clk_i),
    .sys_rst_i    (sys_rst_i),
    .sat_pps_i    (sat_pps_i),
    .utc_sec_i    (utc_sec_i),
    .local_sec_i  (local_sec_i),
    .par_o        (par_o),
    .aux_pin_oe_o (aux_pin_oe_o),
    .ana_en_o     (ana_en_o),
    .pps_o        (pps_o),
    .kpps_o       (kpps_o)
);

// >>> pbt_ext_reader.sv
// pbt_ext_reader: far-side equipment latching the parallel time lines.
// assumes the unit's outputs on the same clock; drives the serial lines.
module pbt_ext_reader
    import pbt_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic [MAIN_W-1:0] par_i,
    input  wire logic              pps_i,
    output logic [AUX_N-1:0]       line_o,
    output pbt_time_t              cap_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pps_d  = 1'b0;
    logic pps_dd = 1'b0;

    // rx line low, cts line high
    assign line_o = 4'h6;
    // latch the bus two clocks after each second edge, once it has settled
    always @(posedge clk_i) begin
        pps_d  <= pps_i;
        pps_dd <= pps_d;
        if (pps_d && !pps_dd) begin
            cap_o <= par_i[TIME_W-1:0];
        end
    end
endmodule : pbt_ext_reader

// >>> test_parallel_bcd_time_output.sv
// test_parallel_bcd_time_output: register and timing tests of the unit.
// assumes a 20-cycle millisecond so a second pulse fits the run.
module test_parallel_bcd_time_output
    import pbt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int          MS   = 20;
    localparam logic [47:0] WORD = 48'ha5c3_1e7b_4d96;
    localparam pbt_sec_t    UTC  = 30'h1234_5678;
    localparam pbt_sec_t    LOC  = 30'h2345_6781;

    logic                 sys_clk_i       = 1'b0;
    logic                 sys_rst_i       = 1'b1;
    logic                 sat_pps_i       = 1'b0;
    logic [DIG_SRC_N-1:0] dig_src_i       = '0;
    logic                 ser_txd_i       = 1'b1;
    logic                 ser_rts_i       = 1'b1;
    logic [4:0]           avs_address_i   = 5'h00;
    logic                 avs_read_i      = 1'b0;
    logic                 avs_write_i     = 1'b0;
    logic [31:0]          avs_writedata_i = 32'h0;
    logic                 ser_rxd_o, ser_cts_o, avs_waitrequest_o;
    logic                 pps_o, kpps_o;
    logic [31:0]          avs_readdata_o, q;
    logic [MAIN_W-1:0]    par_o;
    logic [AUX_N-1:0]     aux_pin_o, aux_pin_oe_o, ext_drv, aux_w;
    logic [ANA_N-1:0]     ana_en_o, ana_sel_o;
    pbt_time_t            cap;
    int                   err_total = 0, total_checks = 0, cyc = 0;

    assign aux_w = (aux_pin_oe_o & aux_pin_o) | (~aux_pin_oe_o & ext_drv);
    always #10 sys_clk_i = ~sys_clk_i;

    pbt_par_time #(.MS_CYCLES(MS), .DATA_WORD(WORD)) dut_u (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
        .sat_pps_i(sat_pps_i), .utc_sec_i(UTC), .local_sec_i(LOC),
        .dig_src_i(dig_src_i), .ser_txd_i(ser_txd_i),
        .ser_rts_i(ser_rts_i), .ser_rxd_o(ser_rxd_o),
        .ser_cts_o(ser_cts_o), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .par_o(par_o),
        .aux_pin_i(aux_w), .aux_pin_o(aux_pin_o),
        .aux_pin_oe_o(aux_pin_oe_o), .ana_en_o(ana_en_o),
        .ana_sel_o(ana_sel_o), .pps_o(pps_o), .kpps_o(kpps_o));

    pbt_ext_reader ext_u (.clk_i(sys_clk_i), .par_i(par_o),
        .pps_i(pps_o), .line_o(ext_drv), .cap_o(cap));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= wr;
        avs_read_i      <= !wr;
        do begin
            @(posedge sys_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
    endtask : bus

    task automatic wait_pps();
        do begin
            @(posedge sys_clk_i);
        end while (pps_o !== 1'b1);
        sat_pps_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask : wait_pps

    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end

    initial begin
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        bus(1'b0, REG_CTRL, 32'h0);
        chk(q, CTRL_RST);
        bus(1'b0, REG_DSEL, 32'h0);
        chk(q, DSEL_RST);
        bus(1'b0, 5'h02, 32'h0);
        chk(q, UNMAPPED_RD);
        @(posedge sys_clk_i);
        sat_pps_i <= 1'b1;
        wait_pps();
        repeat (3 * MS + MS / 2) @(posedge sys_clk_i);
        chk(par_o[11:0], 12'h003);
        chk(cap, {UTC, 12'h000});
        bus(1'b1, REG_CTRL, 32'h2);
        repeat (7 * MS - 3) @(posedge sys_clk_i);
        chk(par_o[11:0], 12'h010);
        sat_pps_i <= 1'b1;
        wait_pps();
        chk(par_o[41:12], LOC);
        bus(1'b0, REG_TIME_HI, 32'h0);
        chk(q, {22'h0, LOC[29:20]});
        repeat (MS / 2) @(posedge sys_clk_i);
        bus(1'b1, REG_CTRL, 32'h1);
        repeat (2) @(posedge sys_clk_i);
        chk(par_o, WORD[43:0]);
        chk({aux_pin_oe_o, aux_pin_o}, {4'hf, WORD[47:44]});
        bus(1'b0, REG_DATA_LO, 32'h0);
        chk(q, WORD[31:0]);
        bus(1'b1, REG_CTRL, 32'h11);
        for (int c = 0; c < 19; c++) begin
            dig_src_i <= (c < DIG_SRC_N) ? 18'(1) << c : '1;
            bus(1'b1, REG_DSEL, 32'(c));
            repeat (2) @(posedge sys_clk_i);
            chk({aux_pin_oe_o, aux_pin_o[0]}, {4'h1, c < DIG_SRC_N});
        end
        bus(1'b1, REG_CTRL, 32'h3f1);
        bus(1'b1, REG_ASEL, 32'h2);
        repeat (2) @(posedge sys_clk_i);
        chk({ana_en_o, ana_sel_o, aux_pin_oe_o}, 8'hec);
        bus(1'b0, REG_ASEL, 32'h0);
        chk(q, 32'h2);
        bus(1'b1, REG_CTRL, 32'hf9);
        repeat (5) @(posedge sys_clk_i);
        chk({aux_pin_oe_o, aux_pin_o[2], aux_pin_o[0], ser_rxd_o,
             ser_cts_o}, 8'h5d);
        bus(1'b1, REG_CTRL, 32'hf5);
        repeat (4) @(posedge sys_clk_i);
        chk({aux_pin_oe_o, ser_rxd_o, ser_cts_o}, 6'h1c);
        bus(1'b1, REG_STATUS, 32'h0);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(q, 32'h1f);
        stop_test();
    end
endmodule : test_parallel_bcd_time_output
